// *** logic/pfp_device.sv ***
// flash-side command engine of the parallel program port
// assumes pins synchronous to i_ref_clk; flash array is word addressed
//
// Summary of operation
// - strobe low latches selector, data; ready drops
// - programmer tristates bus before lowering enable
// - enable low: drive word, then assert valid
// - enable high: release bus, then deassert valid
// - strobe high again: device raises ready
// - new command first completes pending write
// - read: command, address halves, chained words
// - address reload redirects subsequent reads
// - flush load buffer on page change, command
// - page write chains words, address increments
// - write-lock sets region lock after programming
// - programmer uses write-lock on region's last page
// - erase-then-write erases page before programming
// - erase-write-lock erases, programs, then locks
// - full erase aborts if any region locked
// - set/clear lock by mask, bit0 first
// - get-lock returns lock bits in one read
// - set/clear user bits by pattern
// - get user bits returns mask in one read
// - selector routes word to command, address, data
// - command codes decoded from fixed table
// - write: latch, ready low, execute, ready high
// - transfers start only while ready high
`timescale 1ns/1ns
`default_nettype none
module pfp_device #(
   parameter int FLASH_WORDS  = 1024,   // flash size in 16-bit words
   parameter int PAGE_WORDS   = 16,     // words per page and load buffer
   parameter int LOCK_REGIONS = 16,     // lock bits, one per region
   parameter int NV_BITS      = 8       // general-purpose nv bits
) (
   input  wire logic                    i_ref_clk,
   input  wire logic                    i_rstn,
   pfp_link_if.device                   lnk,
   output var  logic [LOCK_REGIONS-1:0] o_lock_bits,
   output var  logic [NV_BITS-1:0]      o_user_nv_bits
);
   import pfp_pkg::*;

   localparam int IDX_W = $clog2(FLASH_WORDS);                  // word index width
   localparam int PG_W  = $clog2(PAGE_WORDS);                   // word-in-page width
   localparam int RG_W  = $clog2(FLASH_WORDS / LOCK_REGIONS);   // word-in-region width

   // elaboration checks: power-of-two geometry, masks fit a data word
   if ((1 << IDX_W) != FLASH_WORDS || (1 << PG_W) != PAGE_WORDS || PAGE_WORDS < 2 ||
       LOCK_REGIONS < 2 || LOCK_REGIONS > 16 || (FLASH_WORDS / LOCK_REGIONS) < PAGE_WORDS ||
       (1 << $clog2(LOCK_REGIONS)) != LOCK_REGIONS || NV_BITS < 1 || NV_BITS > 16) begin : g_chk
      $error("pfp_device: unsupported geometry");
   end

   typedef enum logic [3:0] {
      D_IDLE, D_DECODE, D_FLUSH, D_ERASE, D_WAIT_OE, D_SHOW, D_WAIT_OEH, D_RELEASE, D_WAIT_HI
   } pfp_dev_state_type;

   ////////////////////////////////////////////////////////////////////////////
   // state
   pfp_dev_state_type         state_q;       // handshake and engine state
   logic [3:0]                sel_q;         // latched selector
   logic [15:0]               dat_q;         // latched data word
   logic [15:0]               cmd_q;         // current command
   logic [15:0]               bcmd_q;        // command the buffer was loaded under
   logic [31:0]               addr_q;        // internal word address
   logic [IDX_W-1:0]          cnt_q;         // flush / erase walker
   logic                      dirty_q;       // load buffer holds words
   logic [IDX_W-PG_W-1:0]     bpage_q;       // page the buffer belongs to
   logic [PAGE_WORDS-1:0]     bval_q;        // words loaded in buffer
   logic [LOCK_REGIONS-1:0]   lock_q;        // region lock bits
   logic [NV_BITS-1:0]        nv_q;          // user nv bits
   logic                      rdy_q;         // ready pin
   logic                      dv_n_q;        // data valid pin
   logic                      doe_n_q;       // bus drive enable, low drives
   logic [15:0]               dout_q;        // word shown on the bus
   logic [15:0]               flash [FLASH_WORDS];   // the flash array
   logic [15:0]               pbuf  [PAGE_WORDS];    // page load buffer

   ////////////////////////////////////////////////////////////////////////////
   // decode
   wire logic [IDX_W-1:0]      cur_idx   = addr_q[IDX_W-1:0];   // upper bits wrap
   wire logic [IDX_W-PG_W-1:0] cur_page  = cur_idx[IDX_W-1:PG_W];
   wire logic [PG_W-1:0]       cnt_w     = cnt_q[PG_W-1:0];
   wire logic [IDX_W-1:0]      fl_idx    = {bpage_q, cnt_w};     // word under flush
   wire logic is_wr   = (cmd_q == CMD_PAGE_WR) || (cmd_q == CMD_WR_LOCK) ||
                        (cmd_q == CMD_ERASE_WR) || (cmd_q == CMD_ERASE_WRL);
   wire logic b_erase = (bcmd_q == CMD_ERASE_WR) || (bcmd_q == CMD_ERASE_WRL);
   wire logic b_lock  = (bcmd_q == CMD_WR_LOCK) || (bcmd_q == CMD_ERASE_WRL);
   wire logic is_cmd  = (sel_q == SEL_CMD);
   wire logic is_dat  = (sel_q == SEL_DATA);
   // pending buffer must reach flash before a new command or another page
   wire logic need_flush = dirty_q && (is_cmd || (is_dat && is_wr && cur_page != bpage_q));
   wire logic flush_last = (cnt_w == PG_W'(PAGE_WORDS - 1));
   wire logic erase_last = (cnt_q == IDX_W'(FLASH_WORDS - 1));
   // plain write can only clear bits; erase variants write the page fresh
   wire logic        fl_we = (state_q == D_ERASE) || (state_q == D_FLUSH && (b_erase || bval_q[cnt_w]));
   wire logic [IDX_W-1:0] fl_wa = (state_q == D_ERASE) ? cnt_q : fl_idx;
   wire logic [15:0] fl_wd = (state_q == D_ERASE) ? ERASED_WORD :
                             !bval_q[cnt_w]         ? ERASED_WORD :
                             b_erase                ? pbuf[cnt_w] : (flash[fl_idx] & pbuf[cnt_w]);

   assign lnk.ready         = rdy_q;
   assign lnk.data_valid_n  = dv_n_q;
   assign lnk.dev_data      = dout_q;
   assign lnk.dev_data_oe_n = doe_n_q;
   assign o_lock_bits       = lock_q;
   assign o_user_nv_bits    = nv_q;

   ////////////////////////////////////////////////////////////////////////////
   // flash array and load buffer storage, no reset
   always_ff @(posedge i_ref_clk) begin
      if (fl_we) begin
         flash[fl_wa] <= fl_wd;
      end
      if (state_q == D_DECODE && is_dat && is_wr && !need_flush) begin
         pbuf[cur_idx[PG_W-1:0]] <= dat_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // handshake and command engine
   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         state_q <= D_IDLE;
         sel_q   <= SEL_CMD;
         dat_q   <= CMD_RST;
         cmd_q   <= CMD_RST;
         bcmd_q  <= CMD_RST;
         addr_q  <= ADDR_RST;
         cnt_q   <= '0;
         dirty_q <= 1'b0;
         bpage_q <= '0;
         bval_q  <= '0;
         lock_q  <= '0;
         nv_q    <= '0;
         rdy_q   <= 1'b1;
         dv_n_q  <= 1'b1;
         doe_n_q <= 1'b1;
         dout_q  <= ERASED_WORD;
      end else begin
         unique case (state_q)
            // wait for a strobe; latch the transfer on it
            D_IDLE: begin
               if (!lnk.command_strobe_n) begin
                  sel_q   <= lnk.register_selector;
                  dat_q   <= lnk.bidir_data_bus;
                  rdy_q   <= 1'b0;
                  state_q <= D_DECODE;
               end
            end
            // act on the latched word
            D_DECODE: begin
               if (need_flush) begin
                  cnt_q   <= '0;
                  state_q <= D_FLUSH;
               end else begin
                  state_q <= D_WAIT_HI;               // default: write transfer done
                  unique case (sel_q)
                     SEL_CMD:     cmd_q <= dat_q;
                     SEL_ADDR_LO: addr_q[15:0]  <= dat_q;
                     SEL_ADDR_HI: addr_q[31:16] <= dat_q;
                     SEL_DATA: begin
                        if (is_wr) begin
                           bval_q[cur_idx[PG_W-1:0]] <= 1'b1;
                           dirty_q <= 1'b1;
                           bpage_q <= cur_page;
                           bcmd_q  <= cmd_q;
                           addr_q  <= addr_q + 32'h0000_0001;
                        end else if (cmd_q == CMD_READ) begin
                           dout_q  <= flash[cur_idx];
                           addr_q  <= addr_q + 32'h0000_0001;
                           state_q <= D_WAIT_OE;
                        end else if (cmd_q == CMD_GET_LOCK) begin
                           dout_q  <= 16'(lock_q);
                           state_q <= D_WAIT_OE;
                        end else if (cmd_q == CMD_GET_NV) begin
                           dout_q  <= 16'(nv_q);
                           state_q <= D_WAIT_OE;
                        end else if (cmd_q == CMD_FULL_ERS) begin
                           // locked region or nonzero word: nothing erased
                           if (lock_q == '0 && dat_q == 16'h0000) begin
                              cnt_q   <= '0;
                              state_q <= D_ERASE;
                           end
                        end else if (cmd_q == CMD_SET_LOCK) begin
                           lock_q <= lock_q | dat_q[LOCK_REGIONS-1:0];
                        end else if (cmd_q == CMD_CLR_LOCK) begin
                           lock_q <= lock_q & ~dat_q[LOCK_REGIONS-1:0];
                        end else if (cmd_q == CMD_SET_NV) begin
                           nv_q <= nv_q | dat_q[NV_BITS-1:0];
                        end else if (cmd_q == CMD_CLR_NV) begin
                           nv_q <= nv_q & ~dat_q[NV_BITS-1:0];
                        end
                        // any other command: word dropped, handshake still closes
                     end
                     default: ;   // unmapped selector: no register
                  endcase
               end
            end
            // one page word per cycle, then lock if asked, then retry decode
            D_FLUSH: begin
               cnt_q <= cnt_q + IDX_W'(1);
               if (flush_last) begin
                  dirty_q <= 1'b0;
                  bval_q  <= '0;
                  if (b_lock) begin
                     lock_q[fl_idx[IDX_W-1:RG_W]] <= 1'b1;
                  end
                  state_q <= D_DECODE;
               end
            end
            // whole-array erase, one word per cycle
            D_ERASE: begin
               cnt_q <= cnt_q + IDX_W'(1);
               if (erase_last) begin
                  state_q <= D_WAIT_HI;
               end
            end
            // read: drive only after the programmer lets go of the bus
            D_WAIT_OE: begin
               if (!lnk.output_enable_n) begin
                  doe_n_q <= 1'b0;
                  state_q <= D_SHOW;
               end
            end
            // word is on the bus a full cycle before valid falls
            D_SHOW: begin
               dv_n_q  <= 1'b0;
               state_q <= D_WAIT_OEH;
            end
            D_WAIT_OEH: begin
               if (lnk.output_enable_n) begin
                  doe_n_q <= 1'b1;
                  state_q <= D_RELEASE;
               end
            end
            // valid rises only after the bus is released
            D_RELEASE: begin
               dv_n_q  <= 1'b1;
               state_q <= D_WAIT_HI;
            end
            // close every transfer once the strobe is back high
            D_WAIT_HI: begin
               if (lnk.command_strobe_n) begin
                  rdy_q   <= 1'b1;
                  state_q <= D_IDLE;
               end
            end
         endcase
      end
   end
endmodule : pfp_device
`default_nettype wire

// *** logic/pfp_pkg.sv ***
// shared constants of the parallel flash program port
// assumes both ends and the link interface import it
package pfp_pkg;
   // register selector codes
   localparam logic [3:0]  SEL_CMD       = 4'h0;   // command register
   localparam logic [3:0]  SEL_ADDR_LO   = 4'h1;   // address low half
   localparam logic [3:0]  SEL_ADDR_HI   = 4'h2;   // address high half
   localparam logic [3:0]  SEL_DATA      = 4'h5;   // data register
   // command words
   localparam logic [15:0] CMD_READ      = 16'h0011;
   localparam logic [15:0] CMD_PAGE_WR   = 16'h0012;
   localparam logic [15:0] CMD_WR_LOCK   = 16'h0022;   // page_write_lock_cmd
   localparam logic [15:0] CMD_ERASE_WR  = 16'h0032;   // erase_then_write_cmd
   localparam logic [15:0] CMD_ERASE_WRL = 16'h0042;   // erase_write_lock_cmd
   localparam logic [15:0] CMD_FULL_ERS  = 16'h0013;   // full_erase_cmd
   localparam logic [15:0] CMD_SET_LOCK  = 16'h0014;   // set_region_lock_cmd
   localparam logic [15:0] CMD_CLR_LOCK  = 16'h0024;   // clear_region_lock_cmd
   localparam logic [15:0] CMD_GET_LOCK  = 16'h0015;   // get_region_lock_cmd
   localparam logic [15:0] CMD_SET_NV    = 16'h0034;   // set_user_nv_bits_cmd
   localparam logic [15:0] CMD_CLR_NV    = 16'h0044;   // clear_user_nv_bits_cmd
   localparam logic [15:0] CMD_GET_NV    = 16'h0025;   // get_user_nv_bits_cmd
   // values
   localparam logic [15:0] ERASED_WORD   = 16'hffff;   // erased flash cell
   localparam logic [15:0] BUS_IDLE      = 16'hffff;   // pulled-up bus level
   localparam logic [15:0] CMD_RST       = 16'h0000;   // no command after reset
   localparam logic [31:0] ADDR_RST      = 32'h0000_0000;
endpackage : pfp_pkg

// *** logic/pfp_link_if.sv ***
// link between the flash device port and the programmer
// assumes the testbench instantiates it and joins both ends
`timescale 1ns/1ns
`default_nettype none
interface pfp_link_if;
   import pfp_pkg::*;
   logic        command_strobe_n;   // programmer strobe, active low
   logic        output_enable_n;    // programmer read enable, active low
   logic [3:0]  register_selector;  // target register of a transfer
   logic        ready;              // device ready, high when idle
   logic        data_valid_n;       // device word valid, active low
   logic [15:0] prog_data;          // programmer drive value
   logic        prog_data_oe_n;     // low while programmer drives
   logic [15:0] dev_data;           // device drive value
   logic        dev_data_oe_n;      // low while device drives
   wire  [15:0] bidir_data_bus;     // resolved bus level
   // resolve the shared bus; pull-up when nobody drives
   assign bidir_data_bus = !dev_data_oe_n  ? dev_data  :
                           !prog_data_oe_n ? prog_data : BUS_IDLE;
   modport device (
      input  command_strobe_n, output_enable_n, register_selector, bidir_data_bus,
      output ready, data_valid_n, dev_data, dev_data_oe_n
   );
   modport programmer (
      output command_strobe_n, output_enable_n, register_selector, prog_data, prog_data_oe_n,
      input  ready, data_valid_n, bidir_data_bus
   );
endinterface : pfp_link_if
`default_nettype wire

// *** logic/pfp_programmer.sv ***
// programmer end: turns user requests into write or read handshakes
// assumes pins synchronous to i_ref_clk; read words leave through a small buffer
`timescale 1ns/1ns
`default_nettype none
module pfp_programmer #(
   parameter int RSP_DEPTH = 2   // read buffer entries
) (
   input  wire logic        i_ref_clk,
   input  wire logic        i_rstn,
   pfp_link_if.programmer   lnk,
   input  wire logic        i_req_valid,   // request offered
   input  wire logic        i_req_read,    // 1: read handshake, 0: write
   input  wire logic [3:0]  i_req_sel,     // register selector
   input  wire logic [15:0] i_req_data,    // write word
   output var  logic        o_req_ready,   // request taken when both high
   output var  logic        o_rsp_valid,   // read word available
   output var  logic [15:0] o_rsp_data,    // read word
   input  wire logic        i_rsp_ready    // user takes the word
);
   import pfp_pkg::*;

   localparam int PW = $clog2(RSP_DEPTH);   // buffer pointer width

   // elaboration check: power-of-two depth of at least two
   if (RSP_DEPTH < 2 || (1 << PW) != RSP_DEPTH) begin : g_chk
      $error("pfp_programmer: RSP_DEPTH must be a power of two >= 2");
   end

   typedef enum logic [3:0] {
      P_IDLE, P_START, P_WAIT_BUSY, P_RAISE, P_R_OE, P_R_WAIT_DV, P_R_WAIT_DVH, P_R_STROBE, P_WAIT_DONE
   } pfp_prg_state_type;

   ////////////////////////////////////////////////////////////////////////////
   // state
   pfp_prg_state_type state_q;        // handshake state
   logic              rd_q;           // transfer is a read
   logic              stb_n_q;        // strobe pin
   logic              oe_n_q;         // output enable pin
   logic              drv_n_q;        // bus drive enable, low drives
   logic [3:0]        sel_q;          // selector pins
   logic [15:0]       dat_q;          // drive value
   logic              req_rdy_q;      // request ready
   logic [15:0]       mem [RSP_DEPTH];   // read buffer
   logic [PW-1:0]     wp_q;           // write pointer
   logic [PW-1:0]     rp_q;           // read pointer
   logic [PW:0]       cnt_q;          // occupancy
   logic              rsp_vld_q;      // response valid flop
   logic [15:0]       rsp_dat_q;      // response word flop

   wire logic take = i_req_valid && req_rdy_q;
   wire logic push = (state_q == P_R_WAIT_DV) && !lnk.data_valid_n;
   wire logic pop  = (cnt_q != '0) && i_rsp_ready;
   wire logic [PW:0] cnt_d = cnt_q + (PW+1)'(push) - (PW+1)'(pop);
   // a stalled reader blocks new requests, so no read word is ever dropped
   wire logic space_d = (cnt_d < (PW+1)'(RSP_DEPTH));
   // next head word, so both response outputs leave straight from flops
   wire logic [PW-1:0] rp_d   = rp_q + PW'(pop);
   wire logic          fresh  = (cnt_q == (PW+1)'(pop));   // nothing older stays: head is the bus word
   wire logic [15:0]   head_d = fresh ? lnk.bidir_data_bus : mem[rp_d];

   assign lnk.command_strobe_n  = stb_n_q;
   assign lnk.output_enable_n   = oe_n_q;
   assign lnk.register_selector = sel_q;
   assign lnk.prog_data         = dat_q;
   assign lnk.prog_data_oe_n    = drv_n_q;
   assign o_req_ready           = req_rdy_q;
   assign o_rsp_valid           = rsp_vld_q;
   assign o_rsp_data            = rsp_dat_q;

   ////////////////////////////////////////////////////////////////////////////
   // read buffer storage
   always_ff @(posedge i_ref_clk) begin
      if (push) begin
         mem[wp_q] <= lnk.bidir_data_bus;   // sampled while valid is low
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pointers and handshake sequencer
   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         state_q   <= P_IDLE;
         rd_q      <= 1'b0;
         stb_n_q   <= 1'b1;
         oe_n_q    <= 1'b1;
         drv_n_q   <= 1'b1;
         sel_q     <= SEL_CMD;
         dat_q     <= BUS_IDLE;
         req_rdy_q <= 1'b0;
         wp_q      <= '0;
         rp_q      <= '0;
         cnt_q     <= '0;
         rsp_vld_q <= 1'b0;
         rsp_dat_q <= BUS_IDLE;
      end else begin
         cnt_q <= cnt_d;
         rsp_vld_q <= (cnt_d != '0);
         rsp_dat_q <= head_d;
         if (push) begin
            wp_q <= wp_q + PW'(1);
         end
         if (pop) begin
            rp_q <= rp_q + PW'(1);
         end
         unique case (state_q)
            // offer ready; on a take put selector and data out first
            P_IDLE: begin
               req_rdy_q <= space_d && !take;
               if (take) begin
                  rd_q    <= i_req_read;
                  sel_q   <= i_req_sel;
                  dat_q   <= i_req_data;
                  drv_n_q <= 1'b0;
                  state_q <= P_START;
               end
            end
            // setup held one cycle; strobe only while the device is ready
            P_START: begin
               if (lnk.ready) begin
                  stb_n_q <= 1'b0;
                  state_q <= P_WAIT_BUSY;
               end
            end
            // device took the word; write releases, read tristates
            P_WAIT_BUSY: begin
               if (!lnk.ready) begin
                  drv_n_q <= 1'b1;
                  state_q <= rd_q ? P_R_OE : P_RAISE;
               end
            end
            P_RAISE: begin
               stb_n_q <= 1'b1;
               state_q <= P_WAIT_DONE;
            end
            // bus already released a cycle earlier
            P_R_OE: begin
               oe_n_q  <= 1'b0;
               state_q <= P_R_WAIT_DV;
            end
            P_R_WAIT_DV: begin
               if (!lnk.data_valid_n) begin
                  oe_n_q  <= 1'b1;
                  state_q <= P_R_WAIT_DVH;
               end
            end
            P_R_WAIT_DVH: begin
               if (lnk.data_valid_n) begin
                  drv_n_q <= 1'b0;
                  state_q <= P_R_STROBE;
               end
            end
            P_R_STROBE: begin
               stb_n_q <= 1'b1;
               state_q <= P_WAIT_DONE;
            end
            // transfer ends with strobe and ready both high
            P_WAIT_DONE: begin
               if (lnk.ready) begin
                  drv_n_q   <= 1'b1;
                  req_rdy_q <= space_d;
                  state_q   <= P_IDLE;
               end
            end
         endcase
      end
   end
endmodule : pfp_programmer
`default_nettype wire

// *** testbench/pfp_props.sv ***
// link handshake checker for the program port
// assumes the bench wires it to the link signals
`timescale 1ns/1ns
`default_nettype none
module pfp_props (
   input wire logic i_ref_clk,
   input wire logic i_rstn,
   input wire logic command_strobe_n,
   input wire logic output_enable_n,
   input wire logic ready,
   input wire logic data_valid_n,
   input wire logic dev_data_oe_n,
   input wire logic prog_data_oe_n
);
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_rstn);
   // strobe seen while idle, and a read waiting for its word
   sequence s_take; ready && !command_strobe_n; endsequence
   sequence s_wait; !ready && !output_enable_n && dev_data_oe_n && data_valid_n; endsequence
   a_take_busy: assert property (s_take |=> !ready) else $error("ready kept");
   a_hold_busy: assert property (!ready && !command_strobe_n |=> !ready) else $error("ready early");
   a_valid_drv: assert property ($fell(data_valid_n) |-> !dev_data_oe_n && !output_enable_n) else $error("dv");
   a_valid_soon: assert property (s_wait |-> ##[1:4] !data_valid_n) else $error("no word");
   a_release_first: assert property ($rose(data_valid_n) |-> dev_data_oe_n && output_enable_n) else $error("rel");
   a_release_soon: assert property (output_enable_n && !data_valid_n |-> ##[1:3] data_valid_n) else $error("dv");
   a_ready_last: assert property ($rose(ready) |-> command_strobe_n && data_valid_n) else $error("rdy");
   a_no_fight: assert property (!dev_data_oe_n |-> prog_data_oe_n) else $error("bus contention");
endmodule : pfp_props
`default_nettype wire

// *** testbench/tb_top.sv ***
// bench joining programmer and device ends
// assumes the package, link and both ends compiled first
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   import pfp_pkg::*;
   logic        i_ref_clk = 1'b0, i_rstn = 1'b0, req_valid = 1'b0, req_read = 1'b0, rsp_ready = 1'b0;
   logic        o_req_ready, o_rsp_valid;
   logic [3:0]  req_sel = 4'h0, lock, xl = 4'h0;
   logic [7:0]  nv;
   logic [15:0] req_data = 16'h0000, rsp_data, wd [4], exp_q [$];
   int          seed = 32'h5718, miscompares = 0, comparisons = 0;
   localparam logic [15:0] WC [4] = '{16'h0000, CMD_ERASE_WR, CMD_WR_LOCK, CMD_ERASE_WRL};
   always #5 i_ref_clk = ~i_ref_clk;
   pfp_link_if lnk ();
   // small array keeps erase and flush short
   pfp_device #(.FLASH_WORDS(64), .PAGE_WORDS(4), .LOCK_REGIONS(4), .NV_BITS(8)) u_pfp_device (.i_ref_clk,
      .i_rstn, .lnk(lnk), .o_lock_bits(lock), .o_user_nv_bits(nv));
   pfp_programmer u_pfp_programmer (.i_ref_clk, .i_rstn, .lnk(lnk), .i_req_valid(req_valid),
      .i_req_read(req_read), .i_req_sel(req_sel), .i_req_data(req_data), .o_req_ready,
      .o_rsp_valid, .o_rsp_data(rsp_data), .i_rsp_ready(rsp_ready));
   pfp_props u_pfp_props (.i_ref_clk, .i_rstn, .command_strobe_n(lnk.command_strobe_n),
      .output_enable_n(lnk.output_enable_n), .ready(lnk.ready), .data_valid_n(lnk.data_valid_n),
      .dev_data_oe_n(lnk.dev_data_oe_n), .prog_data_oe_n(lnk.prog_data_oe_n));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      comparisons++;
      if (g !== e) begin
         miscompares++;
         $display("Error %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk
   // one link transfer; held until the programmer takes it
   task automatic xfer(input logic rd, input logic [3:0] s, input logic [15:0] d);
      @(posedge i_ref_clk);
      req_valid <= 1'b1;
      req_read  <= rd;
      req_sel   <= s;
      req_data  <= d;
      do @(posedge i_ref_clk); while (o_req_ready !== 1'b1);
      req_valid <= 1'b0;
   endtask : xfer
   // wait until the transfer just taken has closed on the link
   task automatic settle;
      do @(posedge i_ref_clk); while (o_req_ready !== 1'b1);
   endtask : settle
   task automatic op(input logic [15:0] c, input logic [15:0] d);
      xfer(1'b0, SEL_CMD, c);
      xfer(1'b0, SEL_DATA, d);
   endtask : op
   task automatic at(input logic [15:0] c, input int a);
      xfer(1'b0, SEL_CMD, c);
      xfer(1'b0, SEL_ADDR_LO, 16'(a));
      xfer(1'b0, SEL_ADDR_HI, 16'h0000);
   endtask : at
   task automatic rdw(input logic [15:0] e);
      exp_q.push_back(e);
      xfer(1'b1, SEL_DATA, 16'h0000);
   endtask : rdw
   task automatic give_verdict;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : give_verdict
   // random stalls let the read buffer fill and refuse
   always @(posedge i_ref_clk) begin
      rsp_ready <= ($random(seed) & 1) != 0;
      if (o_rsp_valid === 1'b1 && rsp_ready === 1'b1) begin
         chk(rsp_data, exp_q.pop_front());
      end
   end
   initial begin
      #300us;
      miscompares++;
      give_verdict();
   end
   initial begin
      repeat (20) @(posedge i_ref_clk);
      i_rstn <= 1'b1;
      op(CMD_FULL_ERS, 16'h0000);
      at(CMD_PAGE_WR, 5);
      for (int i = 0; i < 4; i++) begin
         wd[i] = 16'($random(seed));
         xfer(1'b0, SEL_DATA, wd[i]);
      end
      at(CMD_READ, 5);
      for (int i = 0; i < 4; i++) begin
         rdw(wd[i]);
      end
      xfer(1'b0, SEL_ADDR_LO, 16'h0006);
      xfer(1'b0, SEL_ADDR_HI, 16'h0000);
      rdw(wd[1]);
      op(CMD_SET_LOCK, 16'h0001);
      settle();
      chk(16'(lock), 16'h0001);
      xfer(1'b0, SEL_CMD, CMD_GET_LOCK);
      rdw(16'h0001);
      op(CMD_FULL_ERS, 16'h0000);
      at(CMD_READ, 5);
      rdw(wd[0]);
      op(CMD_CLR_LOCK, 16'h0001);
      settle();
      chk(16'(lock), 16'h0000);
      for (int i = 1; i < 4; i++) begin
         at(CMD_PAGE_WR, 16 * i + 13);
         xfer(1'b0, SEL_DATA, 16'h0000);
         at(WC[i], 16 * i + 12);
         xfer(1'b0, SEL_DATA, 16'h1234);
         at(CMD_READ, 16 * i + 12);
         rdw(16'h1234);
         rdw(i == 2 ? 16'h0000 : ERASED_WORD);
         xl[i] = i > 1;
         chk(16'(lock), 16'(xl));
      end
      op(CMD_SET_NV, 16'h00a5);
      op(CMD_CLR_NV, 16'h0005);
      settle();
      chk(16'(nv), 16'h00a0);
      xfer(1'b0, SEL_CMD, CMD_GET_NV);
      rdw(16'h00a0);
      op(16'h0077, 16'hffff);
      xfer(1'b0, 4'h7, CMD_CLR_LOCK);
      xfer(1'b0, SEL_DATA, 16'hffff);
      settle();
      chk(16'(lock), 16'h000c);
      chk(16'(nv), 16'h00a0);
      while (exp_q.size() != 0) @(posedge i_ref_clk);
      give_verdict();
   end
endmodule : tb_top
`default_nettype wire
